// file: design/vd_front.sv
// command front end of the video decoder: queues, executor, buffer, display window
//
// The strobed register port and the register offsets were chosen for this implementation.
module vd_front (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic dma_valid,
    input wire logic [31:0] dma_data,
    output logic dma_ready,
    output logic bs_valid,
    output logic [31:0] bs_data,
    input wire logic bs_ready,
    output logic bs_flush,
    input wire logic [2:0] vlc_bits,
    output logic data_wanted,
    output logic decode_run,
    output logic iframe_only,
    output logic still_double,
    output logic show_hold,
    input wire logic decode_done,
    input wire logic [5:0] coded_fps,
    output logic pic_advance,
    output logic color_convert,
    output logic ucode_restart,
    output logic pkt_start,
    output logic [26:0] pkt_len,
    input wire logic [10:0] core_event,
    output logic irq_n,
    output logic dram_req,
    output logic dram_we,
    output logic [21:0] dram_addr,
    output logic [31:0] dram_wdata,
    input wire logic [31:0] dram_rdata,
    input wire logic dram_ack,
    input wire logic hsync_n,
    input wire logic vsync_n,
    output logic pix_active,
    output logic pix_blank,
    output logic pix_half,
    output logic [8:0] src_x,
    output logic [8:0] src_y
);
    localparam int CW = 64;
    localparam logic [26:0] T_INC = 27'(vd_pkg::TIMER_HZ);
    localparam logic [26:0] T_TOP = 27'(vd_pkg::CLK_HZ);
    localparam logic [22:0] WORD_INC = 23'(vd_pkg::WORD_BITS);
    localparam logic [2:0] VLC_LIM = 3'(vd_pkg::VLC_MAX);

    typedef struct packed {
        vd_pkg::vd_mode_type mode;
        logic blank;
        logic color;
        logic fmt50;
        logic center;
        logic [10:0] bord_x;
        logic [9:0] bord_y;
        logic [8:0] win_w;
        logic [8:0] win_h;
        logic [8:0] crop_x;
        logic [8:0] crop_y;
        logic [10:0] imask;
        logic [10:0] istat;
        logic [22:0] thresh;
        logic [22:0] full;
        logic [22:0] fq;
        logic want;
        logic swap;
        logic ovf;
        logic [31:0] ext;
        logic [31:0] timer;
        logic [26:0] tacc;
        logic [31:0] tsnap;
        logic [3:0] slow_f;
        logic [3:0] slow_c;
        logic [6:0] racc;
        logic dbl;
        logic hs_m, hs_s, hs_d;
        logic vs_m, vs_s, vs_d;
        logic [10:0] hcnt;
        logic [9:0] vcnt;
        logic pix_act, pix_blk, half;
        logic [8:0] sx, sy;
        logic pic_adv, flush, urst, pkt;
        logic [26:0] pkt_len;
        logic dram_req, dram_we;
        logic [21:0] dram_addr;
        logic [31:0] dram_wd, dram_rd;
        logic [31:0] rdata;
    } vd_state_type;

    vd_state_type r, next_r;

    // power-on and command-reset values
    function automatic vd_state_type init_state();
        vd_state_type s;
        s = '0;
        s.mode = vd_pkg::M_IDLE;
        s.center = 1'b1;
        s.win_w = vd_pkg::SRC_W_DEF;
        s.win_h = vd_pkg::SRC_H_DEF;
        s.slow_f = 4'h2;
        s.hs_m = 1'b1;
        s.hs_s = 1'b1;
        s.hs_d = 1'b1;
        s.vs_m = 1'b1;
        s.vs_s = 1'b1;
        s.vs_d = 1'b1;
        return s;
    endfunction

    logic hi_in, lo_in, hi_v, lo_v, hi_rdy, lo_rdy, hi_pop, lo_pop;
    logic [CW-1:0] hi_d, lo_d, cmd;
    logic [3:0] hi_lvl, lo_lvl;
    logic cmd_wr, is_ctrl, exec;
    logic [4:0] op, in_op;
    logic [26:0] arg;
    logic pio_wr, cd_in_v, cd_in_rdy;
    logic [31:0] cd_in, raw_in;
    logic [4:0] cd_lvl;

    // commands split by class on entry so high ones can overtake
    assign cmd_wr = wr && addr == vd_pkg::A_CMD;
    assign in_op = wdata[31:vd_pkg::OP_LSB];
    assign is_ctrl = in_op >= vd_pkg::OP_TIMER && in_op != vd_pkg::OP_PACKET;
    assign hi_in = cmd_wr & is_ctrl;
    assign lo_in = cmd_wr & ~is_ctrl;
    assign hi_pop = hi_v;
    assign lo_pop = lo_v & ~hi_v;
    assign cmd = hi_v ? hi_d : lo_d;
    assign exec = hi_v | lo_v;
    assign op = cmd[31:vd_pkg::OP_LSB];
    assign arg = cmd[26:0];

    vd_fifo #(.W(CW), .DL(vd_pkg::CMD_DEPTH_LOG2)) u_hi_q (
        .sys_clk(sys_clk), .srst(srst), .clr(r.urst),
        .in_valid(hi_in), .in_data({r.ext, wdata}), .in_ready(hi_rdy),
        .out_valid(hi_v), .out_data(hi_d), .out_ready(hi_pop), .level(hi_lvl)
    );

    vd_fifo #(.W(CW), .DL(vd_pkg::CMD_DEPTH_LOG2)) u_lo_q (
        .sys_clk(sys_clk), .srst(srst), .clr(r.urst),
        .in_valid(lo_in), .in_data({r.ext, wdata}), .in_ready(lo_rdy),
        .out_valid(lo_v), .out_data(lo_d), .out_ready(lo_pop), .level(lo_lvl)
    );

    // register writes win the data fifo over dma; dma just stalls a cycle
    assign pio_wr = wr && addr == vd_pkg::A_DATA;
    assign raw_in = pio_wr ? wdata : dma_data;
    assign cd_in = r.swap ? {raw_in[7:0], raw_in[15:8], raw_in[23:16], raw_in[31:24]} : raw_in;
    assign cd_in_v = pio_wr | dma_valid;
    assign dma_ready = cd_in_rdy & ~pio_wr;

    vd_fifo #(.W(32), .DL(vd_pkg::DATA_DEPTH_LOG2)) u_data_q (
        .sys_clk(sys_clk), .srst(srst), .clr(r.flush | r.urst),
        .in_valid(cd_in_v), .in_data(cd_in), .in_ready(cd_in_rdy),
        .out_valid(bs_valid), .out_data(bs_data), .out_ready(bs_ready), .level(cd_lvl)
    );

    logic hs_edge, vs_edge, in_win, want_now;
    logic [10:0] x0, xoff, x_end;
    logic [9:0] y0, yoff, scr_h;
    logic [6:0] disp_rate, racc_sum;
    logic [2:0] take;
    logic [22:0] full_in;
    logic [26:0] tsum;

    // falling edges of the active-low syncs, read from second stage onward
    assign hs_edge = r.hs_d & ~r.hs_s;
    assign vs_edge = r.vs_d & ~r.vs_s;
    assign scr_h = r.fmt50 ? vd_pkg::SCR_H50 : vd_pkg::SCR_H60;
    // default centring until a location command; a window wider or taller than the screen wraps the offset
    assign x0 = r.center ? 11'((vd_pkg::SCR_W - {1'b0, r.win_w, 1'b0}) >> 1) : r.bord_x;
    assign y0 = r.center ? 10'((scr_h - {1'b0, r.win_h}) >> 1) : r.bord_y;
    assign xoff = r.hcnt - x0;
    assign yoff = r.vcnt - y0;
    assign x_end = x0 + {1'b0, r.win_w, 1'b0};
    assign in_win = r.hcnt >= x0 && r.hcnt < x_end && r.vcnt >= y0 && yoff < {1'b0, r.win_h};
    assign disp_rate = r.fmt50 ? vd_pkg::RATE_50 : vd_pkg::RATE_60;
    assign racc_sum = r.racc + {1'b0, coded_fps};
    // a bit count never goes below zero, whatever the core claims
    assign take = vlc_bits > VLC_LIM ? VLC_LIM : vlc_bits;
    assign full_in = (bs_valid & bs_ready) ? r.full + WORD_INC : r.full;
    assign want_now = r.full < r.thresh;
    assign tsum = r.tacc + T_INC;

    always_comb begin
        next_r = r;
        next_r.pic_adv = 1'b0;
        next_r.flush = 1'b0;
        next_r.urst = 1'b0;
        next_r.pkt = 1'b0;
        next_r.rdata = '0;

        // two-stage sync of the sync pins
        next_r.hs_m = hsync_n;
        next_r.hs_s = r.hs_m;
        next_r.hs_d = r.hs_s;
        next_r.vs_m = vsync_n;
        next_r.vs_s = r.vs_m;
        next_r.vs_d = r.vs_s;

        // fractional divider keeps the long-run rate exact at 90 kHz
        if (tsum >= T_TOP) begin
            next_r.tacc = tsum - T_TOP;
            next_r.timer = r.timer + 32'h1;
        end else begin
            next_r.tacc = tsum;
        end

        // buffer occupancy in bits
        next_r.full = full_in > 23'(take) ? full_in - 23'(take) : '0;
        next_r.want = want_now;

        // raster counters locked to the external syncs
        next_r.hcnt = hs_edge ? '0 : r.hcnt + 11'h1;
        if (vs_edge) begin
            next_r.vcnt = '0;
        end else if (hs_edge) begin
            next_r.vcnt = r.vcnt + 10'h1;
        end
        next_r.pix_act = in_win;
        next_r.pix_blk = r.blank | ~in_win;
        next_r.half = xoff[0];
        next_r.sx = r.crop_x + xoff[9:1];
        next_r.sy = r.crop_y + yoff[8:0];

        // picture repeat: rate accumulator steps once per display frame in play, once per slow_f frames in slow
        if (vs_edge && (r.mode == vd_pkg::M_PLAY || r.mode == vd_pkg::M_SLOW)) begin
            next_r.slow_c = (r.mode == vd_pkg::M_SLOW && r.slow_c != r.slow_f - 4'h1) ? r.slow_c + 4'h1 : '0;
            if (r.slow_c == '0 || r.mode == vd_pkg::M_PLAY) begin
                if (racc_sum >= disp_rate) begin
                    next_r.racc = racc_sum - disp_rate;
                    next_r.pic_adv = 1'b1;
                end else begin
                    next_r.racc = racc_sum;
                end
            end
        end

        // one-shot modes settle into a held picture
        if (decode_done) begin
            case (r.mode)
                vd_pkg::M_SCAN,
                vd_pkg::M_STEP,
                vd_pkg::M_STILL: begin
                    next_r.mode = vd_pkg::M_PAUSE;
                    next_r.pic_adv = r.mode != vd_pkg::M_STEP;
                end
                default: begin
                end
            endcase
        end

        // sticky interrupt status, the set beats a clear in the same cycle
        if (wr && addr == vd_pkg::A_IRQ) begin
            next_r.istat = r.istat & ~wdata[10:0];
        end
        next_r.istat = next_r.istat | core_event;
        next_r.istat[vd_pkg::IRQ_RDY] = next_r.istat[vd_pkg::IRQ_RDY] | (want_now & ~r.want);
        next_r.istat[vd_pkg::IRQ_PICV] = next_r.istat[vd_pkg::IRQ_PICV] | r.pic_adv;
        next_r.istat[vd_pkg::IRQ_SCN] = next_r.istat[vd_pkg::IRQ_SCN] | (decode_done && r.mode == vd_pkg::M_SCAN);

        // transparent dram access; request stands until acknowledged
        if (dram_ack) begin
            next_r.dram_req = 1'b0;
            if (!r.dram_we) begin
                next_r.dram_rd = dram_rdata;
            end
        end

        // plain register writes
        if (wr) begin
            case (addr)
                vd_pkg::A_ARG: next_r.ext = wdata;
                vd_pkg::A_CTRL: next_r.swap = wdata[0];
                vd_pkg::A_DADDR: begin
                    next_r.dram_addr = wdata[21:0];
                    next_r.dram_req = wdata[31];
                    next_r.dram_we = 1'b0;
                end
                vd_pkg::A_DDATA: begin
                    next_r.dram_wd = wdata;
                    next_r.dram_req = 1'b1;
                    next_r.dram_we = 1'b1;
                end
                vd_pkg::A_CMD: next_r.ovf = r.ovf | (is_ctrl ? ~hi_rdy : ~lo_rdy);
                default: begin
                end
            endcase
        end

        // read data in the cycle after the strobe; unmapped reads give zero
        if (rd) begin
            case (addr)
                vd_pkg::A_STATUS: next_r.rdata = {r.ovf, 1'b0, cd_lvl, hi_lvl, lo_lvl, r.want, r.blank, r.fmt50,
                    r.color, 2'b00, r.swap, 3'h0, r.mode};
                vd_pkg::A_IRQ: next_r.rdata = {5'h00, r.imask, 5'h00, r.istat};
                vd_pkg::A_FULL: next_r.rdata = {9'h000, r.fq};
                vd_pkg::A_TIMER: next_r.rdata = r.tsnap;
                vd_pkg::A_DDATA: next_r.rdata = r.dram_rd;
                vd_pkg::A_ARG: next_r.rdata = r.ext;
                vd_pkg::A_CTRL: next_r.rdata = {31'h0, r.swap};
                default: next_r.rdata = '0;
            endcase
        end

        // executor, one queued command per cycle
        if (exec) begin
            case (op)
                vd_pkg::OP_BLANK: next_r.blank = arg[0];
                vd_pkg::OP_LOCATION: begin
                    next_r.bord_x = arg[10:0];
                    next_r.bord_y = arg[20:11];
                    next_r.center = 1'b0;
                end
                vd_pkg::OP_COLOR: next_r.color = arg[0];
                vd_pkg::OP_IRQMASK: next_r.imask = arg[10:0];
                vd_pkg::OP_THRESH: next_r.thresh = arg[22:0];
                vd_pkg::OP_FORMAT: next_r.fmt50 = arg[0];
                vd_pkg::OP_CROP: begin
                    next_r.win_w = arg[8:0];
                    next_r.win_h = arg[17:9];
                    next_r.crop_x = arg[26:18];
                    next_r.crop_y = cmd[40:32];
                end
                vd_pkg::OP_STILL: begin
                    next_r.mode = vd_pkg::M_STILL;
                    next_r.dbl = arg[0];
                end
                vd_pkg::OP_PAUSE: next_r.mode = vd_pkg::M_PAUSE;
                vd_pkg::OP_PLAY: next_r.mode = vd_pkg::M_PLAY;
                vd_pkg::OP_SCAN: next_r.mode = vd_pkg::M_SCAN;
                vd_pkg::OP_STEP: next_r.mode = vd_pkg::M_STEP;
                vd_pkg::OP_SLOW: begin
                    next_r.mode = vd_pkg::M_SLOW;
                    next_r.slow_f = arg[3:0] < 4'h2 ? 4'h2 : arg[3:0];
                    next_r.slow_c = '0;
                end
                vd_pkg::OP_TIMER: begin
                    next_r.tsnap = r.timer;
                    if (arg[0]) begin
                        next_r.timer = cmd[63:32];
                        next_r.tacc = '0;
                    end
                end
                vd_pkg::OP_DISCARD: begin
                    next_r.flush = 1'b1;
                    next_r.full = '0;
                end
                vd_pkg::OP_QUERY: next_r.fq = r.full;
                vd_pkg::OP_PACKET: begin
                    next_r.pkt = 1'b1;
                    next_r.pkt_len = arg;
                end
                vd_pkg::OP_RESET: begin
                    next_r = init_state();
                    next_r.timer = r.timer;
                    next_r.tacc = r.tacc;
                    next_r.urst = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            r <= init_state();
        end else begin
            r <= next_r;
        end
    end

    // outputs
    assign rdata = r.rdata;
    assign bs_flush = r.flush;
    assign data_wanted = r.want;
    assign decode_run = r.mode != vd_pkg::M_IDLE && r.mode != vd_pkg::M_PAUSE;
    assign iframe_only = r.mode == vd_pkg::M_SCAN;
    assign still_double = r.dbl;
    assign show_hold = r.mode == vd_pkg::M_PAUSE || r.mode == vd_pkg::M_STEP;
    assign pic_advance = r.pic_adv;
    assign color_convert = r.color;
    assign ucode_restart = r.urst;
    assign pkt_start = r.pkt;
    assign pkt_len = r.pkt_len;
    assign irq_n = ~|(r.istat & r.imask);
    assign dram_req = r.dram_req;
    assign dram_we = r.dram_we;
    assign dram_addr = r.dram_addr;
    assign dram_wdata = r.dram_wd;
    assign pix_active = r.pix_act;
    assign pix_blank = r.pix_blk;
    assign pix_half = r.half;
    assign src_x = r.sx;
    assign src_y = r.sy;
endmodule

// file: design/vd_pkg.sv
// shared constants for the video decoder command front end
package vd_pkg;
    localparam int CLK_HZ = 125000000;
    localparam int TIMER_HZ = 90000;
    localparam int WORD_BITS = 32;
    localparam int VLC_MAX = 4;
    localparam int CMD_DEPTH_LOG2 = 3;
    localparam int DATA_DEPTH_LOG2 = 4;
    localparam int NUM_IRQ = 11;
    // register byte addresses
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_DATA = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_IRQ = 8'h0C;
    localparam logic [7:0] A_FULL = 8'h10;
    localparam logic [7:0] A_TIMER = 8'h14;
    localparam logic [7:0] A_CTRL = 8'h18;
    localparam logic [7:0] A_DADDR = 8'h1C;
    localparam logic [7:0] A_DDATA = 8'h20;
    localparam logic [7:0] A_ARG = 8'h24;
    // command word: opcode in [31:27], argument in [26:0]
    localparam int OP_LSB = 27;
    localparam logic [4:0] OP_BLANK = 5'h00;
    localparam logic [4:0] OP_LOCATION = 5'h01;
    localparam logic [4:0] OP_COLOR = 5'h02;
    localparam logic [4:0] OP_IRQMASK = 5'h03;
    localparam logic [4:0] OP_THRESH = 5'h04;
    localparam logic [4:0] OP_FORMAT = 5'h05;
    localparam logic [4:0] OP_CROP = 5'h06;
    localparam logic [4:0] OP_STILL = 5'h07;
    localparam logic [4:0] OP_PAUSE = 5'h08;
    localparam logic [4:0] OP_PLAY = 5'h09;
    localparam logic [4:0] OP_SCAN = 5'h0A;
    localparam logic [4:0] OP_STEP = 5'h0B;
    localparam logic [4:0] OP_SLOW = 5'h0C;
    localparam logic [4:0] OP_TIMER = 5'h0D;
    localparam logic [4:0] OP_DISCARD = 5'h0E;
    localparam logic [4:0] OP_QUERY = 5'h0F;
    localparam logic [4:0] OP_PACKET = 5'h10;
    localparam logic [4:0] OP_RESET = 5'h11;
    // interrupt status bit positions
    localparam int IRQ_RDY = 10;
    localparam int IRQ_PICV = 8;
    localparam int IRQ_SCN = 4;
    // display geometry and rates
    localparam logic [10:0] SCR_W = 11'h2D0;
    localparam logic [9:0] SCR_H60 = 10'h0F0;
    localparam logic [9:0] SCR_H50 = 10'h120;
    localparam logic [8:0] SRC_W_DEF = 9'h160;
    localparam logic [8:0] SRC_H_DEF = 9'h0F0;
    localparam logic [6:0] RATE_50 = 7'h32;
    localparam logic [6:0] RATE_60 = 7'h3C;
    typedef enum logic [6:0] {
        M_IDLE = 7'h01,
        M_PLAY = 7'h02,
        M_SLOW = 7'h04,
        M_PAUSE = 7'h08,
        M_SCAN = 7'h10,
        M_STEP = 7'h20,
        M_STILL = 7'h40
    } vd_mode_type;
endpackage

// file: design/vd_fifo.sv
// synchronous fifo with valid/ready on both sides and a clear
module vd_fifo #(
    parameter int W = 32,
    parameter int DL = 4
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clr,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready,
    output logic [DL:0] level
);
    localparam logic [DL:0] DEPTH = (DL+1)'(1 << DL);
    typedef struct packed {
        logic [(1<<DL)-1:0][W-1:0] mem;
        logic [DL-1:0] wp;
        logic [DL-1:0] rp;
        logic [DL:0] cnt;
    } vd_fifo_type;
    vd_fifo_type r, next_r;
    logic push, pop;

    // honest flags straight from the count
    assign in_ready = r.cnt != DEPTH;
    assign out_valid = r.cnt != '0;
    assign out_data = r.mem[r.rp];
    assign level = r.cnt;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wp] = in_data;
            next_r.wp = r.wp + 1'b1;
        end
        if (pop) begin
            next_r.rp = r.rp + 1'b1;
        end
        next_r.cnt = r.cnt + (DL+1)'(push) - (DL+1)'(pop);
        // clear drops everything, including a push in the same cycle
        if (clr) begin
            next_r.wp = '0;
            next_r.rp = '0;
            next_r.cnt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule

// file: verification/vd_front_checker.sv
// port assertions for the decoder command front end
module vd_front_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic irq_n,
    input wire logic dma_ready,
    input wire logic bs_flush,
    input wire logic ucode_restart,
    input wire logic decode_run,
    input wire logic iframe_only,
    input wire logic show_hold,
    input wire logic pic_advance,
    input wire logic dram_req,
    input wire logic dram_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // rdata must read zero outside its one-cycle slot
    a_rdata_idle_zero: assert property (!rd |=> rdata == 32'h0) else $error("read data outside slot");
    a_flush_one_pulse: assert property (bs_flush |=> !bs_flush) else $error("flush pulse too long");
    a_restart_one_pulse: assert property (ucode_restart |=> !ucode_restart) else $error("restart too long");
    // reset must not be masked by the default disable
    a_reset_quiet_state: assert property (disable iff (1'b0)
        srst |=> irq_n && dma_ready && !decode_run && !show_hold) else $error("state after reset wrong");
    a_restart_mode_idle: assert property (ucode_restart |-> !decode_run && !show_hold)
        else $error("restart not idle");
    a_dram_req_hold: assert property (dram_req && !dram_ack |=> dram_req)
        else $error("memory request dropped");
    a_scan_mode_runs: assert property (iframe_only |-> decode_run && !show_hold)
        else $error("scan not decoding");
    a_advance_one_pulse: assert property (pic_advance |=> !pic_advance) else $error("advance too long");
    // main scenarios reached
    c_flush: cover property (bs_flush);
    c_restart: cover property (ucode_restart);
    c_scan: cover property (iframe_only);
endmodule

bind vd_front vd_front_checker chk (.sys_clk, .srst, .rd, .rdata, .irq_n, .dma_ready, .bs_flush, .ucode_restart,
    .decode_run, .iframe_only, .show_hold, .pic_advance, .dram_req, .dram_ack);

// file: verification/vd_far_model.sv
// far-side model: stalling bitstream sink and a slow local memory
module vd_far_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic dram_req,
    output logic bs_ready,
    output logic dram_ack,
    output logic [31:0] dram_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;
    logic answer;
    assign answer = dram_req && !dram_ack && wait_cnt == 2'h2;
    // sink stalls every other cycle; memory data is garbage except on ack
    always_ff @(posedge sys_clk) begin
        bs_ready <= srst ? 1'b0 : ~bs_ready;
        wait_cnt <= (dram_req && !dram_ack && !srst) ? wait_cnt + 2'h1 : 2'h0;
        dram_ack <= !srst && answer;
        dram_rdata <= srst ? 32'h0 : (answer ? 32'hC0DE_0001 : ~dram_rdata);
    end
endmodule

// file: verification/vd_front_test.sv
// self-checking bench for the decoder command front end
module vd_front_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, dma_valid = 1'b0, decode_done = 1'b0;
    logic hsync_n = 1'b1, vsync_n = 1'b1, bs_ready, dram_ack, dram_req, irq_n, iframe_only, dma_ready;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, dram_rdata, v, bs_data;
    logic [10:0] core_event = 11'h000;
    int n_errors = 0, checked = 0;
    logic [4:0] ops [5] = '{vd_pkg::OP_PLAY, vd_pkg::OP_SLOW, vd_pkg::OP_PAUSE, vd_pkg::OP_STEP, vd_pkg::OP_SCAN};
    vd_pkg::vd_mode_type modes [5] = '{vd_pkg::M_PLAY, vd_pkg::M_SLOW, vd_pkg::M_PAUSE, vd_pkg::M_STEP, vd_pkg::M_SCAN};
    logic [4:0] sets [3] = '{vd_pkg::OP_BLANK, vd_pkg::OP_FORMAT, vd_pkg::OP_COLOR};
    vd_front dut (.sys_clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .dma_valid, .dma_data(32'h1122_3344), .dma_ready,
        .bs_valid(), .bs_data, .bs_ready, .bs_flush(), .vlc_bits(3'h0), .data_wanted(), .decode_run(), .iframe_only,
        .still_double(), .show_hold(), .decode_done, .coded_fps(6'h1E), .pic_advance(), .color_convert(),
        .ucode_restart(), .pkt_start(), .pkt_len(), .core_event, .irq_n, .dram_req, .dram_we(), .dram_addr(),
        .dram_wdata(), .dram_rdata, .dram_ack, .hsync_n, .vsync_n, .pix_active(), .pix_blank(), .pix_half(),
        .src_x(), .src_y());
    vd_far_model far (.sys_clk, .srst, .dram_req, .bs_ready, .dram_ack, .dram_rdata);
    // 125 MHz clock and free-running syncs
    always #4 sys_clk = ~sys_clk;
    always begin
        repeat (60) @(posedge sys_clk);
        hsync_n <= 1'b0;
        @(posedge sys_clk);
        hsync_n <= 1'b1;
    end
    always begin
        repeat (3000) @(posedge sys_clk);
        vsync_n <= 1'b0;
        @(posedge sys_clk);
        vsync_n <= 1'b1;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    // read data stands one cycle only, so sample just after that edge
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic cmd(input logic [4:0] op, input logic [26:0] arg);
        wr_reg(vd_pkg::A_CMD, {op, arg});
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic close_out;
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #400000;
        n_errors++;
        close_out;
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        rd_reg(vd_pkg::A_STATUS, v);
        check(v & 32'h0000_E07F, 32'h1);
        rd_reg(8'h3C, v);
        check(v, 32'h0);
        for (int i = 0; i < 5; i++) begin
            cmd(ops[i], 27'h2);
            rd_reg(vd_pkg::A_STATUS, v);
            check(v & 32'h7F, {25'h0, modes[i]});
        end
        @(posedge sys_clk);
        decode_done <= 1'b1;
        @(posedge sys_clk);
        decode_done <= 1'b0;
        rd_reg(vd_pkg::A_STATUS, v);
        check(v & 32'h7F, {25'h0, vd_pkg::M_PAUSE});
        for (int i = 0; i < 3; i++) begin
            cmd(sets[i], 27'h1);
            rd_reg(vd_pkg::A_STATUS, v);
            check({31'h0, v[15-i]}, 32'h1);
        end
        wr_reg(vd_pkg::A_ARG, 32'h0000_1000);
        cmd(vd_pkg::OP_TIMER, 27'h1);
        cmd(vd_pkg::OP_TIMER, 27'h0);
        rd_reg(vd_pkg::A_TIMER, v);
        check({31'h0, (v - 32'h1000) < 32'h2}, 32'h1);
        // two words by register, one by dma, drained through a stalling sink
        wr_reg(vd_pkg::A_DATA, 32'hA1B2_C3D4);
        wr_reg(vd_pkg::A_DATA, 32'h0102_0304);
        @(posedge sys_clk);
        dma_valid <= 1'b1;
        @(posedge sys_clk);
        while (!dma_ready) @(posedge sys_clk);
        dma_valid <= 1'b0;
        repeat (12) @(posedge sys_clk);
        cmd(vd_pkg::OP_QUERY, 27'h0);
        rd_reg(vd_pkg::A_FULL, v);
        check(v, 32'h60);
        cmd(vd_pkg::OP_DISCARD, 27'h0);
        cmd(vd_pkg::OP_QUERY, 27'h0);
        rd_reg(vd_pkg::A_FULL, v);
        check(v, 32'h0);
        cmd(vd_pkg::OP_IRQMASK, 27'h1);
        @(posedge sys_clk);
        core_event <= 11'h001;
        @(posedge sys_clk);
        core_event <= 11'h000;
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq_n}, 32'h0);
        rd_reg(vd_pkg::A_IRQ, v);
        check(v & 32'h1, 32'h1);
        wr_reg(vd_pkg::A_IRQ, 32'h1);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq_n}, 32'h1);
        cmd(vd_pkg::OP_PLAY, 27'h0);
        cmd(vd_pkg::OP_RESET, 27'h0);
        rd_reg(vd_pkg::A_STATUS, v);
        check(v & 32'h7F, {25'h0, vd_pkg::M_IDLE});
        // byte-reversed word sits at the empty fifo head for two cycles
        wr_reg(vd_pkg::A_CTRL, 32'h1);
        wr_reg(vd_pkg::A_DATA, 32'hA1B2_C3D4);
        #1;
        check(bs_data, 32'hD4C3_B2A1);
        wr_reg(vd_pkg::A_DADDR, 32'h8000_0010);
        repeat (8) @(posedge sys_clk);
        rd_reg(vd_pkg::A_DDATA, v);
        check(v, 32'hC0DE_0001);
        close_out;
    end
endmodule
